// ==== src/config_access_pkg.sv ====
// constants for the configuration space and bit access attributes
package config_access_pkg;

  // -------------------------------------------------------------
  // function map and device number
  // -------------------------------------------------------------
  localparam logic [4:0] DEV_NUM = 5'h00;
  localparam logic [2:0] FN_BRIDGE_A = 3'h0;
  localparam logic [2:0] FN_APIC_A = 3'h1;
  localparam logic [2:0] FN_BRIDGE_B = 3'h2;
  localparam logic [2:0] FN_APIC_B = 3'h3;

  // -------------------------------------------------------------
  // configuration offsets (byte addresses)
  // -------------------------------------------------------------
  localparam logic [7:0] OFS_ID = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_MEM_BASE = 8'h10;
  localparam logic [7:0] OFS_CAP_PTR = 8'h34;
  localparam logic [7:0] OFS_ALT_BASE = 8'h40;
  localparam logic [7:0] OFS_ATTR = 8'h48;
  localparam logic [7:0] OFS_HP_CAP = 8'h80;
  localparam logic [7:0] OFS_HP_MEM_BASE = OFS_HP_CAP + OFS_MEM_BASE;
  localparam logic [7:0] HP_CAP_ID = 8'h0c;

  // -------------------------------------------------------------
  // field layouts and reset values
  // -------------------------------------------------------------
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [31:0] CMD_RW_M = 32'h0000_0006;
  localparam logic [31:0] CMD_W1C_M = 32'h2000_0000;
  localparam logic [31:0] CMD_RESET = 32'h0010_0000;
  localparam int CMD_MASTER_BIT = 2;
  localparam int STS_MABORT_BIT = 29;
  localparam logic [31:0] ATTR_W1C_M = 32'h0000_0001;
  localparam logic [31:0] ATTR_W1CS_M = 32'h0000_0002;
  localparam logic [31:0] ATTR_ROS_M = 32'h0000_00f0;
  localparam logic [31:0] ATTR_RWS_M = 32'h0000_ff00;
  localparam logic [31:0] ATTR_WO_M = 32'h00ff_0000;
  localparam int ATTR_EVENT_BIT = 0;
  localparam int ATTR_FATAL_BIT = 1;
  localparam int ATTR_DIAG_LSB = 4;
  localparam logic [31:0] BASE_RW_M = 32'hffff_fff0;
  localparam logic [3:0] BE_ALL = 4'hf;
  localparam int NREQ = 4;

  // byte enables widened to a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

endpackage

// ==== src/attr_reg.sv ====
// one 32-bit register whose bits carry mixed access attributes
`timescale 1ns/10ps
`default_nettype none
module attr_reg
  import config_access_pkg::*;
#(
  parameter logic [31:0] RW_M = 32'h0000_0000,
  parameter logic [31:0] W1C_M = 32'h0000_0000,
  parameter logic [31:0] STK_M = 32'h0000_0000,
  parameter logic [31:0] ROS_M = 32'h0000_0000,
  parameter logic [31:0] WO_M = 32'h0000_0000,
  parameter logic [31:0] RESET_V = 32'h0000_0000
)
(
  // clock and resets
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic power_good_reset,
  // software write
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  input wire logic [31:0] wr_mask,
  // hardware side
  input wire logic [31:0] hw_set,
  input wire logic hw_load,
  input wire logic [31:0] hw_value,
  // current contents
  output logic [31:0] value
);

  localparam logic [31:0] FIX_M = ~(RW_M | W1C_M | ROS_M | WO_M);

  logic [31:0] sticky_reg;
  logic [31:0] plain_reg;
  logic locked_reg;
  logic full_rst;
  logic [31:0] wr_sel;
  logic [31:0] clr;
  logic [31:0] upd;
  logic [31:0] value_next;

  // -------------------------------------------------------------
  // next value
  // -------------------------------------------------------------
  assign full_rst = rst | power_good_reset;
  assign value = (sticky_reg & STK_M) | (plain_reg & ~STK_M);
  // read-only bits never appear in the write select
  assign wr_sel = wr_en ? wr_mask & (RW_M | (WO_M & {32{!locked_reg}})) : ZERO;
  assign clr = wr_en ? wr_data & wr_mask & W1C_M : ZERO;
  assign upd = (value & ~wr_sel) | (wr_data & wr_sel);
  // hardware set wins over a clear in the same cycle
  assign value_next = hw_load ? ((upd & ~clr) & ~ROS_M) | (hw_value & ROS_M) | (hw_set & W1C_M)
                              : (upd & ~clr) | (hw_set & W1C_M);

  // -------------------------------------------------------------
  // storage
  // -------------------------------------------------------------
  // sticky half only sees the power-good reset
  always_ff @(posedge clk_sys or posedge power_good_reset)
  begin
    if (power_good_reset)
      sticky_reg <= RESET_V;
    else
      sticky_reg <= value_next;
  end

  // ordinary half sees both resets
  always_ff @(posedge clk_sys or posedge full_rst)
  begin
    if (full_rst)
      plain_reg <= RESET_V;
    else
      plain_reg <= value_next;
  end

  // write-once lock lasts until the next power cycle
  always_ff @(posedge clk_sys or posedge power_good_reset)
  begin
    if (power_good_reset)
      locked_reg <= 1'b0;
    else if (wr_en && |(wr_mask & WO_M))
      locked_reg <= 1'b1;
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  ro_bits_fixed_a: assert property (@(posedge clk_sys) disable iff (full_rst)
    1'b1 |=> (value & FIX_M) == (RESET_V & FIX_M))
    else $error("read-only bits moved");
  ros_sw_ignore_a: assert property (@(posedge clk_sys) disable iff (power_good_reset)
    !hw_load |=> (value & ROS_M) == ($past(value) & ROS_M))
    else $error("read-only sticky bits altered");
  rw_write_lands_a: assert property (@(posedge clk_sys) disable iff (full_rst)
    wr_en |=> ((value ^ $past(wr_data)) & $past(wr_mask) & RW_M) == ZERO)
    else $error("read/write bits lost a write");
  w1c_clear_a: assert property (@(posedge clk_sys) disable iff (full_rst)
    wr_en |=> (value & $past(wr_data) & $past(wr_mask) & W1C_M & ~$past(hw_set)) == ZERO)
    else $error("write one did not clear");
  w1c_zero_keep_a: assert property (@(posedge clk_sys) disable iff (full_rst)
    wr_en && hw_set == ZERO |=>
      ((value ^ $past(value)) & ~($past(wr_data) & $past(wr_mask)) & W1C_M) == ZERO)
    else $error("written zero changed a clear bit");
  sticky_survive_a: assert property (@(posedge clk_sys) disable iff (power_good_reset)
    rst && !wr_en && hw_set == ZERO && !hw_load |=>
      (value & STK_M) == ($past(value) & STK_M))
    else $error("sticky bits lost in full reset");
  wo_locked_hold_a: assert property (@(posedge clk_sys) disable iff (power_good_reset)
    locked_reg && wr_en |=> (value & WO_M) == ($past(value) & WO_M))
    else $error("write-once bits written twice");
  plain_reset_a: assert property (@(posedge clk_sys) disable iff (power_good_reset)
    rst |-> (value & ~STK_M) == (RESET_V & ~STK_M))
    else $error("plain bits not at default in reset");

endmodule // attr_reg
`default_nettype wire

// ==== src/bus_arbiter.sv ====
// round-robin arbiter for one secondary bus segment
`timescale 1ns/10ps
`default_nettype none
module bus_arbiter
  import config_access_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic enable,
  // requests and grants
  input wire logic [NREQ-1:0] req,
  output logic [NREQ-1:0] gnt_reg
);

  logic [1:0] last_reg;
  logic [1:0] pick;
  logic found;
  logic [NREQ-1:0] gnt_next;

  // -------------------------------------------------------------
  // selection
  // -------------------------------------------------------------
  // owner keeps the bus while still asking, else next in turn
  always_comb
  begin
    logic [1:0] idx;
    idx = last_reg;
    pick = last_reg;
    found = 1'b0;
    gnt_next = '0;
    for (int i = 1; i <= NREQ; i++)
    begin
      idx = last_reg + 2'(i);
      if (!found && req[idx])
      begin
        found = 1'b1;
        pick = idx;
      end
    end
    if (gnt_reg[last_reg] && req[last_reg])
      pick = last_reg;
    if (enable && found)
      gnt_next[pick] = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      gnt_reg <= '0;
      last_reg <= 2'h0;
    end
    else
    begin
      gnt_reg <= gnt_next;
      last_reg <= pick;
    end
  end

  grant_gated_a: assert property (@(posedge clk_sys) disable iff (rst)
    !enable |=> gnt_reg == '0 && $onehot0(gnt_reg))
    else $error("grant while arbiter disabled");

endmodule // bus_arbiter
`default_nettype wire

// ==== src/config_access_attributes.sv ====
// configuration space of the bridge hub: function map, bases, attributes
`timescale 1ns/10ps
`default_nettype none
module config_access_attributes
  import config_access_pkg::*;
#(
  parameter logic TWO_SEGMENTS = 1'b1,
  // identity values are arbitrary
  parameter logic [15:0] VENDOR_ID = 16'h1234,
  parameter logic [15:0] BRIDGE_DEV_ID = 16'h0001,
  parameter logic [15:0] APIC_DEV_ID = 16'h0002
)
(
  // clock and resets
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic power_good_reset,
  // configuration request
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [4:0] cfg_dev,
  input wire logic [2:0] cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  // configuration answer
  output logic cfg_ack_reg,
  output logic cfg_ur_reg,
  output logic [31:0] cfg_rdata_reg,
  // bridge events, index 0 is bus A
  input wire logic [1:0] mabort_event,
  input wire logic [1:0] err_event,
  input wire logic [1:0] fatal_event,
  input wire logic [1:0] diag_load,
  input wire logic [3:0] diag_code_a,
  input wire logic [3:0] diag_code_b,
  // secondary bus arbitration
  input wire logic [NREQ-1:0] bus_a_req,
  input wire logic [NREQ-1:0] bus_b_req,
  output logic [NREQ-1:0] bus_a_gnt,
  output logic [NREQ-1:0] bus_b_gnt
);

  // -------------------------------------------------------------
  // request decode
  // -------------------------------------------------------------
  logic [7:0] addr_dw;
  logic dev_ok;
  logic fn_ok;
  logic is_apic;
  logic sel;
  logic wr_ok;
  logic [31:0] wmask;

  // matches the dword-aligned offset
  function automatic logic at(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  assign addr_dw = {cfg_addr[7:2], 2'b00};
  assign dev_ok = cfg_dev == DEV_NUM;
  // functions 2 and 3 only exist in the two-segment variant
  assign fn_ok = !cfg_func[2] && (TWO_SEGMENTS || !cfg_func[1]);
  assign is_apic = cfg_func[0];
  assign sel = cfg_func[1];
  assign wr_ok = cfg_req && cfg_we && dev_ok && fn_ok;
  assign wmask = be_mask(cfg_be);
  // the management port is not decoded here at all
  // (its fields live behind that port only)

  // -------------------------------------------------------------
  // per-segment registers
  // -------------------------------------------------------------
  logic [31:0] cmd_q [2];
  logic [31:0] attr_q [2];
  logic [31:0] hp_q [2];
  logic [31:0] apic_q [2];
  logic [31:0] alt_q [2];
  logic [NREQ-1:0] gnt_w [2];
  logic [NREQ-1:0] req_w [2];

  assign req_w[0] = bus_a_req;
  assign req_w[1] = bus_b_req;
  assign bus_a_gnt = gnt_w[0];
  assign bus_b_gnt = gnt_w[1];

  generate
    for (genvar s = 0; s < 2; s++)
    begin : g_seg
      logic wr_seg;
      logic wr_bridge;
      logic wr_apic;
      logic [31:0] cmd_set;
      logic [31:0] attr_set;
      logic [31:0] diag_val;

      assign wr_seg = wr_ok && (sel == 1'(s));
      assign wr_bridge = wr_seg && !is_apic;
      assign wr_apic = wr_seg && is_apic;
      assign cmd_set = {ZERO[31:STS_MABORT_BIT+1], mabort_event[s], ZERO[STS_MABORT_BIT-1:0]};
      assign attr_set = {ZERO[31:ATTR_FATAL_BIT+1], fatal_event[s], err_event[s]};
      assign diag_val = {ZERO[31:ATTR_DIAG_LSB+4], (s == 0) ? diag_code_a : diag_code_b,
                         ZERO[ATTR_DIAG_LSB-1:0]};

      // command and status word of the bridge
      attr_reg #(
        .RW_M(CMD_RW_M),
        .W1C_M(CMD_W1C_M),
        .RESET_V(CMD_RESET)
      ) u_cmd (
        .clk_sys(clk_sys),
        .rst(rst),
        .power_good_reset(power_good_reset),
        .wr_en(wr_bridge && at(addr_dw, OFS_CMD)),
        .wr_data(cfg_wdata),
        .wr_mask(wmask),
        .hw_set(cmd_set),
        .hw_load(1'b0),
        .hw_value(ZERO),
        .value(cmd_q[s])
      );

      // mixed attribute word: event flags, diagnostics, scratch, lock
      attr_reg #(
        .RW_M(ATTR_RWS_M),
        .W1C_M(ATTR_W1C_M | ATTR_W1CS_M),
        .STK_M(ATTR_W1CS_M | ATTR_ROS_M | ATTR_RWS_M | ATTR_WO_M),
        .ROS_M(ATTR_ROS_M),
        .WO_M(ATTR_WO_M),
        .RESET_V(ZERO)
      ) u_attr (
        .clk_sys(clk_sys),
        .rst(rst),
        .power_good_reset(power_good_reset),
        .wr_en(wr_bridge && at(addr_dw, OFS_ATTR)),
        .wr_data(cfg_wdata),
        .wr_mask(wmask),
        .hw_set(attr_set),
        .hw_load(diag_load[s]),
        .hw_value(diag_val),
        .value(attr_q[s])
      );

      // hot-plug memory base inside the bridge capability
      attr_reg #(
        .RW_M(BASE_RW_M)
      ) u_hp_base (
        .clk_sys(clk_sys),
        .rst(rst),
        .power_good_reset(power_good_reset),
        .wr_en(wr_bridge && at(addr_dw, OFS_HP_MEM_BASE)),
        .wr_data(cfg_wdata),
        .wr_mask(wmask),
        .hw_set(ZERO),
        .hw_load(1'b0),
        .hw_value(ZERO),
        .value(hp_q[s])
      );

      // interrupt controller memory base
      attr_reg #(
        .RW_M(BASE_RW_M)
      ) u_apic_base (
        .clk_sys(clk_sys),
        .rst(rst),
        .power_good_reset(power_good_reset),
        .wr_en(wr_apic && at(addr_dw, OFS_MEM_BASE)),
        .wr_data(cfg_wdata),
        .wr_mask(wmask),
        .hw_set(ZERO),
        .hw_load(1'b0),
        .hw_value(ZERO),
        .value(apic_q[s])
      );

      // interrupt controller alternate base
      attr_reg #(
        .RW_M(BASE_RW_M)
      ) u_alt_base (
        .clk_sys(clk_sys),
        .rst(rst),
        .power_good_reset(power_good_reset),
        .wr_en(wr_apic && at(addr_dw, OFS_ALT_BASE)),
        .wr_data(cfg_wdata),
        .wr_mask(wmask),
        .hw_set(ZERO),
        .hw_load(1'b0),
        .hw_value(ZERO),
        .value(alt_q[s])
      );

      // arbiter runs only while bus mastering is enabled
      bus_arbiter u_arb (
        .clk_sys(clk_sys),
        .rst(rst),
        .enable(cmd_q[s][CMD_MASTER_BIT]),
        .req(req_w[s]),
        .gnt_reg(gnt_w[s])
      );
    end
  endgenerate

  // -------------------------------------------------------------
  // read path
  // -------------------------------------------------------------
  logic [31:0] apic_rd;
  logic [31:0] bridge_rd;
  logic [31:0] rd_word;
  logic ur_next;

  assign apic_rd = at(addr_dw, OFS_ID) ? {APIC_DEV_ID, VENDOR_ID} :
                   at(addr_dw, OFS_MEM_BASE) ? apic_q[sel] :
                   at(addr_dw, OFS_ALT_BASE) ? alt_q[sel] : ZERO;
  // capability pointer leads to the hot-plug structure
  assign bridge_rd = at(addr_dw, OFS_ID) ? {BRIDGE_DEV_ID, VENDOR_ID} :
                     at(addr_dw, OFS_CMD) ? cmd_q[sel] :
                     at(addr_dw, OFS_CAP_PTR) ? {ZERO[31:8], OFS_HP_CAP} :
                     at(addr_dw, OFS_ATTR) ? attr_q[sel] :
                     at(addr_dw, OFS_HP_CAP) ? {ZERO[31:8], HP_CAP_ID} :
                     at(addr_dw, OFS_HP_MEM_BASE) ? hp_q[sel] : ZERO;
  // absent device or function: unsupported, reads zero
  assign ur_next = !(dev_ok && fn_ok);
  assign rd_word = ur_next ? ZERO : is_apic ? apic_rd : bridge_rd;

  // answer one cycle after each request
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cfg_ack_reg <= 1'b0;
      cfg_ur_reg <= 1'b0;
      cfg_rdata_reg <= ZERO;
    end
    else
    begin
      cfg_ack_reg <= cfg_req;
      cfg_ur_reg <= cfg_req && ur_next;
      cfg_rdata_reg <= (cfg_req && !cfg_we) ? rd_word : ZERO;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  sequence other_dev_s;
    cfg_req && !dev_ok;
  endsequence

  sequence apic_full_wr_s;
    wr_ok && is_apic && cfg_be == BE_ALL && at(addr_dw, OFS_MEM_BASE);
  endsequence

  sequence hp_full_wr_s;
    wr_ok && !is_apic && cfg_be == BE_ALL && at(addr_dw, OFS_HP_MEM_BASE);
  endsequence

  ack_timing_a: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> cfg_ack_reg == $past(cfg_req))
    else $error("answer not one cycle after request");
  other_dev_ur_a: assert property (@(posedge clk_sys) disable iff (rst)
    other_dev_s |=> cfg_ack_reg && cfg_ur_reg && cfg_rdata_reg == ZERO)
    else $error("non-zero device number answered");
  absent_fn_ur_a: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_req && dev_ok && (cfg_func[2] || (!TWO_SEGMENTS && cfg_func[1])) |=> cfg_ur_reg)
    else $error("absent function answered");
  apic_base_wr_a: assert property (@(posedge clk_sys)
    disable iff (rst || power_good_reset)
    apic_full_wr_s |=> apic_q[$past(sel)] == ($past(cfg_wdata) & BASE_RW_M))
    else $error("interrupt controller base not written");
  hp_base_wr_a: assert property (@(posedge clk_sys)
    disable iff (rst || power_good_reset)
    hp_full_wr_s |=> hp_q[$past(sel)] == ($past(cfg_wdata) & BASE_RW_M))
    else $error("hot-plug base not written");

  // a bridge read of the pointer must lead software to the hot-plug structure
  sequence cap_ptr_rd_s;
    cfg_req && !cfg_we && dev_ok && fn_ok && !is_apic && at(addr_dw, OFS_CAP_PTR);
  endsequence

  cap_ptr_a: assert property (@(posedge clk_sys) disable iff (rst)
    cap_ptr_rd_s |=> cfg_rdata_reg == {ZERO[31:8], OFS_HP_CAP})
    else $error("capability pointer lost");
  answer_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
    !cfg_req |=> !cfg_ack_reg && !cfg_ur_reg && cfg_rdata_reg == ZERO)
    else $error("answer without a request");

endmodule // config_access_attributes
`default_nettype wire

// ==== test/cfg_host.sv ====
// host model that issues configuration requests to the block
`timescale 1ns/10ps
`default_nettype none
module cfg_host
(
  // clock
  input wire logic clk_sys,
  // request
  output logic cfg_req,
  output logic cfg_we,
  output logic [4:0] cfg_dev,
  output logic [2:0] cfg_func,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  // answer
  input wire logic cfg_ack_reg,
  input wire logic cfg_ur_reg,
  input wire logic [31:0] cfg_rdata_reg
);
  initial
  begin
    {cfg_req, cfg_we, cfg_dev, cfg_func, cfg_addr, cfg_be, cfg_wdata} = '0;
  end

  // one-cycle strobe; released write, address, enable and data lines flip so stale values never look valid
  task automatic access(input logic we, input logic [4:0] dev, input logic [2:0] fn,
    input logic [7:0] addr, input logic [3:0] be, input logic [31:0] wd,
    output logic [31:0] rd, output logic ur, output logic ack);
    @(posedge clk_sys);
    #1;
    {cfg_req, cfg_we, cfg_dev, cfg_func, cfg_addr, cfg_be, cfg_wdata} = {1'b1, we, dev, fn,
      addr, be, wd};
    @(posedge clk_sys);
    #1;
    {rd, ur, ack} = {cfg_rdata_reg, cfg_ur_reg, cfg_ack_reg};
    cfg_req = 1'b0;
    {cfg_we, cfg_addr, cfg_be, cfg_wdata} = ~{cfg_we, cfg_addr, cfg_be, cfg_wdata};
  endtask

  // read, merge, write back so untouched bits keep their value
  task automatic rmw(input logic [2:0] fn, input logic [7:0] addr, input logic [31:0] set,
    output logic [31:0] wd);
    logic [31:0] rd;
    logic ur;
    logic ack;
    access(1'b0, 5'h00, fn, addr, 4'hf, 32'h0, rd, ur, ack);
    wd = rd | set;
    access(1'b1, 5'h00, fn, addr, 4'hf, wd, rd, ur, ack);
  endtask
endmodule // cfg_host
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the configuration space block
`timescale 1ns/10ps
`default_nettype none
module tb
  import config_access_pkg::*;
;
  localparam logic [15:0] V_ID = 16'h0a5c; // arbitrary
  localparam logic [15:0] B_ID = 16'h0b01; // arbitrary
  localparam logic [15:0] A_ID = 16'h0b02; // arbitrary
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic power_good_reset = 1'b1;
  logic cfg_req, cfg_we, cfg_ack_reg, cfg_ur_reg, ur, ack;
  logic [4:0] cfg_dev;
  logic [2:0] cfg_func;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be, diag_code_a, diag_code_b, bus_a_req, bus_b_req, bus_a_gnt, bus_b_gnt;
  logic [31:0] cfg_wdata, cfg_rdata_reg, rd, wd;
  logic [1:0] mabort_event, err_event, fatal_event, diag_load;
  logic single_ack, single_ur;
  logic [31:0] single_rdata;
  logic [31:0] cmd [4], attr [4], mb [4], ab [4], hb [4];
  logic lock [4];
  logic [7:0] ofs [8] = '{8'h00, 8'h04, 8'h10, 8'h34, 8'h40, 8'h48, 8'h80, 8'h90};
  int failures = 0;
  int samples_checked = 0;

  config_access_attributes #(.TWO_SEGMENTS(1'b1), .VENDOR_ID(V_ID), .BRIDGE_DEV_ID(B_ID),
    .APIC_DEV_ID(A_ID)) i_config_access_attributes (.clk_sys, .rst, .power_good_reset,
    .cfg_req, .cfg_we, .cfg_dev, .cfg_func, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_ack_reg,
    .cfg_ur_reg, .cfg_rdata_reg, .mabort_event, .err_event, .fatal_event, .diag_load,
    .diag_code_a, .diag_code_b, .bus_a_req, .bus_b_req, .bus_a_gnt, .bus_b_gnt);
  cfg_host i_cfg_host (.clk_sys, .cfg_req, .cfg_we, .cfg_dev, .cfg_func, .cfg_addr, .cfg_be,
    .cfg_wdata, .cfg_ack_reg, .cfg_ur_reg, .cfg_rdata_reg);
  // single-segment variant sees the same requests; only its answer is compared
  config_access_attributes #(.TWO_SEGMENTS(1'b0), .VENDOR_ID(V_ID), .BRIDGE_DEV_ID(B_ID),
    .APIC_DEV_ID(A_ID)) i_config_access_attributes_single (.clk_sys, .rst, .power_good_reset,
    .cfg_req, .cfg_we, .cfg_dev, .cfg_func, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_ack_reg(single_ack), .cfg_ur_reg(single_ur), .cfg_rdata_reg(single_rdata),
    .mabort_event, .err_event, .fatal_event, .diag_load, .diag_code_a, .diag_code_b,
    .bus_a_req, .bus_b_req, .bus_a_gnt(), .bus_b_gnt());

  always #5 clk_sys = ~clk_sys;

  // ---------------------------------------------
  // reference model of the register space
  // ---------------------------------------------
  function automatic logic [31:0] mread(input int f, input logic [7:0] a);
    case ({f[0], a})
      9'h000: return {B_ID, V_ID};
      9'h004: return cmd[f];
      9'h034: return 32'h0000_0080;
      9'h048: return attr[f];
      9'h080: return 32'h0000_000c;
      9'h090: return hb[f];
      9'h100: return {A_ID, V_ID};
      9'h110: return mb[f];
      9'h140: return ab[f];
      default: return 32'h0000_0000;
    endcase
  endfunction

  // bases keep bits 3:0 at zero; write-once byte locks on its first enabled write
  function automatic void mwrite(input int f, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] d);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    case ({f[0], a})
      9'h004: cmd[f] = (cmd[f] & ~(m & 32'h6) | d & m & 32'h6) & ~(d & m & 32'h2000_0000);
      9'h048:
      begin
        attr[f] = attr[f] & ~(d & m & 32'h3) & ~(m & 32'hff00) | d & m & 32'hff00;
        if (!lock[f] && be[2])
        begin
          attr[f][23:16] = d[23:16];
          lock[f] = 1'b1;
        end
      end
      9'h090: hb[f] = (hb[f] & ~m | d & m) & 32'hffff_fff0;
      9'h110: mb[f] = (mb[f] & ~m | d & m) & 32'hffff_fff0;
      9'h140: ab[f] = (ab[f] & ~m | d & m) & 32'hffff_fff0;
      default: ;
    endcase
  endfunction

  task automatic chk(input logic ok, input string what);
    samples_checked++;
    if (!ok)
    begin
      failures++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask

  // cap header is compared on its id byte only
  task automatic do_rd(input int f, input logic [7:0] a);
    logic [31:0] m;
    m = (a == 8'h80) ? 32'h0000_00ff : 32'hffff_ffff;
    i_cfg_host.access(1'b0, 5'h00, f[2:0], a, 4'hf, $urandom, rd, ur, ack);
    chk(ack === 1'b1 && ur === 1'b0 && (rd & m) === (mread(f, a) & m), "read mismatch");
  endtask

  task automatic do_wr(input int f, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] d);
    i_cfg_host.access(1'b1, 5'h00, f[2:0], a, be, d, rd, ur, ack);
    chk(ack === 1'b1 && ur === 1'b0 && rd === 32'h0, "write answer");
    mwrite(f, a, be, d);
    do_rd(f, a);
  endtask

  task automatic do_ur(input logic [4:0] dv, input logic [2:0] f, input logic we);
    i_cfg_host.access(we, dv, f, 8'h10, 4'hf, 32'hffff_ffff, rd, ur, ack);
    chk(ack === 1'b1 && ur === 1'b1 && rd === 32'h0, "unsupported answer");
  endtask

  // both variants answer the same id read; the single one refuses functions 2 and 3
  task automatic single_chk(input logic [2:0] f);
    i_cfg_host.access(1'b0, 5'h00, f, 8'h00, 4'hf, 32'h0, rd, ur, ack);
    chk(ack === 1'b1 && ur === 1'b0 && rd === mread(f, 8'h00), "two-segment answer");
    chk(single_ack === 1'b1 && single_ur === f[1], "single-segment answer");
    chk(single_rdata === (f[1] ? 32'h0 : mread(f, 8'h00)), "single-segment data");
  endtask

  task automatic read_all();
    for (int f = 0; f < 4; f++)
    begin
      foreach (ofs[i]) do_rd(f, ofs[i]);
    end
  endtask

  task automatic ev(input logic [1:0] mab, input logic [1:0] er, input logic [1:0] fat,
    input logic [1:0] dl);
    @(posedge clk_sys);
    #1;
    {mabort_event, err_event, fatal_event, diag_load} = {mab, er, fat, dl};
    @(posedge clk_sys);
    #1;
    {mabort_event, err_event, fatal_event, diag_load} = '0;
    for (int s = 0; s < 2; s++)
    begin
      cmd[2*s][29] |= mab[s];
      attr[2*s][1:0] |= {fat[s], er[s]};
      if (dl[s]) attr[2*s][7:4] = s ? diag_code_b : diag_code_a;
    end
  endtask

  // sticky bits survive a full reset; power-good clears them too
  task automatic do_reset(input logic pg);
    @(posedge clk_sys);
    #1;
    {rst, power_good_reset} = {1'b1, pg};
    repeat (4) @(posedge clk_sys);
    #1;
    {rst, power_good_reset} = 2'b00;
    for (int f = 0; f < 4; f++)
    begin
      {cmd[f], mb[f], ab[f], hb[f]} = {CMD_RESET, 96'h0};
      attr[f] &= pg ? 32'h0 : 32'h00ff_fff2;
      lock[f] &= !pg;
    end
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  initial
  begin
    int f;
    {mabort_event, err_event, fatal_event, diag_load} = '0;
    {diag_code_a, diag_code_b, bus_a_req, bus_b_req} = '0;
    void'($urandom(32'h57340791));
    do_reset(1'b1);
    read_all();
    for (f = 0; f < 4; f++)
    begin
      do_wr(f, 8'h00, 4'hf, 32'hffff_ffff);
      do_wr(f, 8'h34, 4'hf, $urandom);
    end
    do_ur(5'h01, 3'h0, 1'b0);
    do_ur(5'h1f, 3'h1, 1'b1);
    for (f = 4; f < 8; f++) do_ur(5'h00, f[2:0], 1'b0);
    for (f = 0; f < 4; f++) single_chk(f[2:0]);
    do_rd(1, 8'h10);
    repeat (16)
    begin
      f = $urandom_range(3);
      do_wr(f, f[0] ? ($urandom_range(1) ? 8'h40 : 8'h10) : 8'h90,
        4'($urandom), $urandom);
    end
    // full-word base writes so the base assertions see their trigger
    for (f = 0; f < 4; f++) do_wr(f, f[0] ? 8'h10 : 8'h90, 4'hf, $urandom);
    {diag_code_a, diag_code_b} = 8'($urandom);
    ev(2'b11, 2'b11, 2'b11, 2'b11);
    for (f = 0; f < 4; f += 2)
    begin
      do_wr(f, 8'h04, 4'hf, 32'hdfff_fff9);
      do_wr(f, 8'h04, 4'h8, 32'h2000_0000);
      do_wr(f, 8'h48, 4'hf, $urandom & 32'hffff_fffc);
      do_wr(f, 8'h48, 4'h4, $urandom);
    end
    do_wr(0, 8'h48, 4'h1, 32'h0000_0002);
    do_wr(2, 8'h48, 4'h1, 32'h0000_0001);
    do_reset(1'b0);
    read_all();
    do_wr(2, 8'h48, 4'h4, 32'h00ab_0000);
    do_reset(1'b1);
    read_all();
    do_wr(0, 8'h48, 4'h4, 32'h005a_0000);
    for (f = 0; f < 4; f += 2)
    begin
      i_cfg_host.rmw(f[2:0], 8'h04, 32'h0000_0004, wd);
      mwrite(f, 8'h04, 4'hf, wd);
    end
    @(posedge clk_sys);
    #1;
    {bus_a_req, bus_b_req} = {4'b0010, 4'b0100};
    @(posedge clk_sys);
    #1;
    chk(bus_a_gnt === 4'b0010 && bus_b_gnt === 4'b0100, "grant mismatch");
    do_wr(0, 8'h04, 4'h1, 32'h0000_0000);
    chk(bus_a_gnt === 4'b0000 && bus_b_gnt === 4'b0100, "grant not dropped");
    test_done();
  end

  // watchdog far beyond the few hundred cycles the run needs
  initial
  begin
    #200000;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end
endmodule // tb
`default_nettype wire
